//--- design/tdsb_pkg.sv
// Constants, field layout and carrier types of the thermal and device
// status bank.
// Assumes one 250 MHz clock shared with the SPI frame decoder.
package tdsb_pkg;

  // Register indices as seen in the SPI address field
  localparam logic [6:0] ADDR_THERM = 7'h41;
  localparam logic [6:0] ADDR_DEV = 7'h42;
  localparam logic [15:0] REG_RESET = 16'h0000;

  // Thermal register field positions
  localparam int TH_PREWARN = 0;
  localparam int TH_THERMAL_STAGE_ONE_SHUTDOWN = 1;
  localparam int TH_THERMAL_STAGE_TWO_SHUTDOWN = 2;
  localparam int TH_SAFE = 3;

  // Device information field positions
  localparam int DV_FAILURE = 0;
  localparam int DV_SPI_FAIL = 1;
  localparam int DV_WD_LO = 2;
  localparam int DV_SOFTWARE_DEVELOPMENT_ACTIVE = 4;
  localparam int DV_PRIOR_LO = 6;
  localparam int DV_CRC_FAIL = 8;
  localparam int DV_CRC_ON = 9;

  // Prior-state codes
  localparam logic [1:0] PRIOR_CLEARED = 2'h0;
  localparam logic [1:0] PRIOR_FAIL = 2'h1;
  localparam logic [1:0] PRIOR_SLEEP = 2'h2;

  // Stage-two events tolerated before the safe state is declared
  localparam logic [4:0] SAFE_AFTER = 5'h10;
  localparam logic [4:0] THERMAL_STAGE_TWO_SHUTDOWN_CNT_MAX = 5'h11;

  // Number of separately disabled power modules
  localparam int NUM_MODULES = 4;
  localparam int WD_W = 2;
  localparam int TMR_W = 40;

  // Waiting times of the stage-two recovery
  localparam longint CLK_HZ = 250_000_000;
  localparam longint T_WAIT_LONG_S = 64;
  localparam longint WAIT_LONG_CYC = T_WAIT_LONG_S * CLK_HZ;
  localparam longint T_WAIT_SHORT_MS = 1000;
  localparam longint WAIT_SHORT_CYC = T_WAIT_SHORT_MS * (CLK_HZ / 1000);

  typedef struct packed {
    logic prewarn;
    logic thermal_stage_one_shutdown;
    logic [NUM_MODULES-1:0] thermal_stage_one_shutdown_module;
    logic thermal_stage_two_shutdown;
    logic thermal_stage_two_shutdown_recovered;
  } tdsb_therm_evt_type;

  typedef struct packed {
    logic crc_error;
    logic crc_static_seq;
    logic invalid_cmd;
    logic failure;
    logic watchdog_failure_count;
    logic wd_good;
    logic fail_restart;
    logic sleep_restart;
  } tdsb_dev_evt_type;

  typedef struct packed {
    logic valid;
    logic [6:0] addr;
    logic read_clear;
  } tdsb_req_type;

endpackage

//--- design/tdsb_sat_counter.sv
// Saturating event counter that the device itself may clear.
// Assumes inc and clr are single-cycle pulses on clk_sys.
`timescale 1ns/100ps
module tdsb_sat_counter #(
  parameter int W = 2
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic ce,
  input wire logic inc,
  input wire logic clr,
  output logic [W-1:0] count
);

  logic [W-1:0] count_r;
  logic [W-1:0] count_nxt;
  wire sat = &count_r;
  wire [W-1:0] one = {{(W-1){1'b0}}, 1'b1};

  // A failure in the clearing cycle still counts, so none is lost
  assign count_nxt = inc ? (clr ? one : (sat ? count_r : count_r + one))
                   : (clr ? '0 : count_r);

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      count_r <= '0;
    end else if (ce) begin
      count_r <= count_nxt;
    end
  end

  assign count = count_r;

endmodule

//--- design/tdsb_status_bank.sv
// Thermal protection and device information status registers.
// Assumes the SPI frame decoder, the thermal sensors and the mode
// controller all run on clk_sys and deliver one-cycle event pulses.
//
// Behaviour
// RULE_01: Over sixteen consecutive stage-two events set safe flag, next wait 64 s.
// RULE_02: Stage-two overtemperature latches its flag and requests Fail-Safe Mode.
// RULE_03: Stage-one overtemperature latches its flag, disables only affected module.
// RULE_04: Thermal pre-warning latches into bit zero of the thermal register.
// RULE_05: Thermal flags persist after the condition ends until host clears them.
// RULE_06: Thermal register bits 15 to 4 always read zero.
// RULE_07: Bit 9 shows CRC enable; CRC bits readable whatever the CRC setting.
// RULE_08: CRC error sets bit 8, except for the static enable/disable sequence.
// RULE_09: Reads of the device-information register skip the frame CRC check.
// RULE_10: Prior-state bits 7:6: 00 cleared, 01 failure, 10 sleep, 11 reserved.
// RULE_11: Watchdog, stage-two, undervoltage, wakeless sleep, fail-safe wake record 01.
// RULE_12: Sleep entry attempted with wake flags pending records Sleep Mode.
// RULE_13: Host clears the prior-state field; the device never clears it itself.
// RULE_14: Bit 4 follows Software Development Mode, updated by hardware.
// RULE_15: Bits 3:2 count watchdog failures, saturating at three.
// RULE_16: Only the watchdog counter is cleared by the device itself.
// RULE_17: An invalid SPI command sets the SPI failure flag in bit 1.
// RULE_18: SPI failure flag clears only by a SPI clear command.
// RULE_19: Both registers zero after reset; restart keeps the latched flags.
// RULE_20: Read-clear flags clear only on a read-and-clear access; reserved ignore writes.
`timescale 1ns/100ps
module tdsb_status_bank #(
  parameter logic [39:0] WAIT_SHORT_CYC =
    40'(tdsb_pkg::WAIT_SHORT_CYC),
  parameter logic [39:0] WAIT_LONG_CYC =
    40'(tdsb_pkg::WAIT_LONG_CYC)
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic ce,
  input wire logic restart,
  input wire tdsb_pkg::tdsb_therm_evt_type therm_evt,
  input wire tdsb_pkg::tdsb_dev_evt_type dev_evt,
  input wire logic crc_enabled,
  input wire logic software_development_active_mode,
  input wire tdsb_pkg::tdsb_req_type req,
  output logic rsp_valid,
  output logic [15:0] rsp_data,
  output logic rsp_crc_bypass,
  output logic fail_safe_req,
  output logic [tdsb_pkg::NUM_MODULES-1:0] module_disable,
  output logic thermal_stage_two_shutdown_waiting,
  output logic long_wait_sel
);

  // Read-and-clear access aimed at one register
  function automatic logic clear_hit(
    input tdsb_pkg::tdsb_req_type r,
    input logic [6:0] a
  );
    clear_hit = r.valid && r.read_clear && (r.addr == a);
  endfunction

  // Thermal flag state
  logic prewarn_r;
  logic prewarn_nxt;
  logic thermal_stage_one_shutdown_r;
  logic thermal_stage_one_shutdown_nxt;
  logic thermal_stage_two_shutdown_r;
  logic thermal_stage_two_shutdown_nxt;
  logic safe_r;
  logic safe_nxt;
  logic [4:0] thermal_stage_two_shutdown_cnt_r;
  logic [4:0] thermal_stage_two_shutdown_cnt_nxt;

  // Device information state
  logic crc_fail_r;
  logic crc_fail_nxt;
  logic spi_fail_r;
  logic spi_fail_nxt;
  logic failure_r;
  logic failure_nxt;
  logic [1:0] prior_r;
  logic [1:0] prior_nxt;
  logic [tdsb_pkg::WD_W-1:0] wd_count;

  // Answer and side outputs
  logic rsp_valid_r;
  logic [15:0] rsp_data_r;
  logic [15:0] rsp_data_nxt;
  logic crc_bypass_r;
  logic crc_bypass_nxt;
  logic fail_safe_r;
  logic [tdsb_pkg::NUM_MODULES-1:0] mod_dis_r;
  logic [tdsb_pkg::NUM_MODULES-1:0] mod_dis_nxt;

  // Register decode. Only the two mapped addresses decode; a
  // read-and-clear aimed anywhere else wipes nothing and answers zero.
  // Decode does not look at ce: the flops below ignore it while frozen,
  // so a request during a frozen cycle is simply never taken.
  wire clr_therm = clear_hit(req, tdsb_pkg::ADDR_THERM); // RULE_20
  wire clr_dev = clear_hit(req, tdsb_pkg::ADDR_DEV); // RULE_20
  wire rd_therm = req.valid && (req.addr == tdsb_pkg::ADDR_THERM);
  wire rd_dev = req.valid && (req.addr == tdsb_pkg::ADDR_DEV);

  // Stage-two bookkeeping: the count runs while no recovery is seen.
  // Each stage-two event bumps the run length and starts a recovery
  // wait; a recovery report ends the run. The count stops one past
  // the threshold, so a long run can never wrap back to short waits.
  // The event that finds the count already at the threshold is the
  // one that declares the safe state, and its own wait is the long one.
  // Limitation: the host clearing the safe flag neither shortens a long
  // wait under way nor resets the run length, so the next event of the
  // same run declares the safe state again.
  wire safe_hit = therm_evt.thermal_stage_two_shutdown && (thermal_stage_two_shutdown_cnt_r >= tdsb_pkg::SAFE_AFTER);
  wire cnt_sat = thermal_stage_two_shutdown_cnt_r == tdsb_pkg::THERMAL_STAGE_TWO_SHUTDOWN_CNT_MAX;
  wire [4:0] cnt_inc = cnt_sat ? thermal_stage_two_shutdown_cnt_r : thermal_stage_two_shutdown_cnt_r + 5'h01;

  assign thermal_stage_two_shutdown_cnt_nxt = therm_evt.thermal_stage_two_shutdown ? cnt_inc
                      : (therm_evt.thermal_stage_two_shutdown_recovered ? 5'h00 : thermal_stage_two_shutdown_cnt_r);

  // Thermal flags: set wins over a clear in the same cycle
  assign prewarn_nxt = therm_evt.prewarn | (prewarn_r & ~clr_therm); // RULE_04
  assign thermal_stage_one_shutdown_nxt = therm_evt.thermal_stage_one_shutdown | (thermal_stage_one_shutdown_r & ~clr_therm); // RULE_03
  assign thermal_stage_two_shutdown_nxt = therm_evt.thermal_stage_two_shutdown | (thermal_stage_two_shutdown_r & ~clr_therm); // RULE_02
  assign safe_nxt = safe_hit | (safe_r & ~clr_therm); // RULE_01

  // Once safe, the following wait uses the long interval
  assign long_wait_sel = safe_hit | safe_r; // RULE_01

  // CRC failure ignores the static enable/disable frame. The frame
  // decoder flags that frame on crc_static_seq in the same cycle as
  // crc_error, so the qualifier must never lag the error by a cycle.
  assign crc_fail_nxt = (dev_evt.crc_error & ~dev_evt.crc_static_seq)
                      | (crc_fail_r & ~clr_dev); // RULE_08

  // SPI failure has no path to clear other than the host command.
  // Reset returns it to zero like every other latched flag; restart does not.
  assign spi_fail_nxt = dev_evt.invalid_cmd | (spi_fail_r & ~clr_dev); // RULE_17 RULE_18
  assign failure_nxt = dev_evt.failure | (failure_r & ~clr_dev); // RULE_20

  // Prior state: failure beats sleep, both beat a host clear.
  // A watchdog failure and a stage-two shutdown count as failure
  // restarts here directly; the mode controller reports the others
  // (undervoltage, wakeless sleep, fail-safe wake) on fail_restart.
  // The reserved code is never produced, since only the two coded
  // values or the cleared value can ever be loaded.
  wire prior_fail = dev_evt.fail_restart | dev_evt.watchdog_failure_count
                  | therm_evt.thermal_stage_two_shutdown; // RULE_11
  assign prior_nxt = prior_fail ? tdsb_pkg::PRIOR_FAIL // RULE_10
                   : (dev_evt.sleep_restart ? tdsb_pkg::PRIOR_SLEEP // RULE_12
                   : (clr_dev ? tdsb_pkg::PRIOR_CLEARED : prior_r)); // RULE_13

  // Watchdog failures: the device clears this on a good service.
  // A failure in the same cycle as a good service leaves a count of
  // one, so the newest failure is never hidden by the clear.
  tdsb_sat_counter #(
    .W(tdsb_pkg::WD_W)
  ) u_wd_count (
    .clk_sys(clk_sys),
    .reset(reset),
    .ce(ce),
    .inc(dev_evt.watchdog_failure_count), // RULE_15
    .clr(dev_evt.wd_good), // RULE_16
    .count(wd_count)
  );

  // Recovery wait after each stage-two shutdown. A restart aborts the
  // wait, but a new event in the same cycle wins, so a shutdown is
  // never left without its wait.
  tdsb_wait_timer #(
    .SHORT_CYC(WAIT_SHORT_CYC),
    .LONG_CYC(WAIT_LONG_CYC)
  ) u_wait (
    .clk_sys(clk_sys),
    .reset(reset),
    .ce(ce),
    .start(therm_evt.thermal_stage_two_shutdown),
    .long_sel(long_wait_sel), // RULE_01
    .abort(restart),
    .busy(thermal_stage_two_shutdown_waiting)
  );

  // Per-module disable; a restart re-enables modules, flags stay.
  // A stage-one event only disables the modules flagged with it, so
  // the others keep running through a local overtemperature.
  genvar gi;
  generate
    for (gi = 0; gi < tdsb_pkg::NUM_MODULES; gi++) begin : g_mod
      assign mod_dis_nxt[gi] = (therm_evt.thermal_stage_one_shutdown && therm_evt.thermal_stage_one_shutdown_module[gi])
                             | (mod_dis_r[gi] & ~restart); // RULE_03
    end
  endgenerate

  // Read words built field by field at the package positions; the
  // reserved bits are tied to zero, so no write can ever land there
  wire [15:0] therm_word;
  wire [15:0] dev_word;

  // Thermal word layout
  //   15:4  reserved, read as zero
  //   3     safe state after a long run of stage-two events
  //   2     stage-two shutdown seen
  //   1     stage-one shutdown seen
  //   0     thermal pre-warning seen
  assign therm_word[15:tdsb_pkg::TH_SAFE+1] = 12'h000; // RULE_06
  assign therm_word[tdsb_pkg::TH_SAFE] = safe_r;
  assign therm_word[tdsb_pkg::TH_THERMAL_STAGE_TWO_SHUTDOWN] = thermal_stage_two_shutdown_r;
  assign therm_word[tdsb_pkg::TH_THERMAL_STAGE_ONE_SHUTDOWN] = thermal_stage_one_shutdown_r;
  assign therm_word[tdsb_pkg::TH_PREWARN] = prewarn_r; // RULE_04

  // Device word layout
  //   15:10 reserved, read as zero
  //   9     frame CRC protection on, live level
  //   8     CRC failure seen
  //   7:6   state before the restart
  //   5     reserved, read as zero
  //   4     development mode active, live level
  //   3:2   watchdog failures, cleared by the device
  //   1     invalid command seen
  //   0     general failure seen
  assign dev_word[15:tdsb_pkg::DV_CRC_ON+1] = 6'h00;
  assign dev_word[tdsb_pkg::DV_CRC_ON] = crc_enabled; // RULE_07
  assign dev_word[tdsb_pkg::DV_CRC_FAIL] = crc_fail_r; // RULE_08
  assign dev_word[tdsb_pkg::DV_PRIOR_LO +: 2] = prior_r; // RULE_10
  assign dev_word[tdsb_pkg::DV_SOFTWARE_DEVELOPMENT_ACTIVE+1] = 1'b0;
  assign dev_word[tdsb_pkg::DV_SOFTWARE_DEVELOPMENT_ACTIVE] = software_development_active_mode; // RULE_14
  assign dev_word[tdsb_pkg::DV_WD_LO +: tdsb_pkg::WD_W] = wd_count;
  assign dev_word[tdsb_pkg::DV_SPI_FAIL] = spi_fail_r; // RULE_17
  assign dev_word[tdsb_pkg::DV_FAILURE] = failure_r;

  // Unmapped addresses answer zero; answers show pre-clear contents
  assign rsp_data_nxt = rd_therm ? therm_word
                      : (rd_dev ? dev_word : tdsb_pkg::REG_RESET);
  assign crc_bypass_nxt = rd_dev; // RULE_09

  // Thermal flags: reset clears, restart leaves them alone.
  // The clock enable freezes flags and run length alike, so an event
  // pulse that arrives while ce is low is lost, not deferred.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      prewarn_r <= 1'b0; // RULE_19
      thermal_stage_one_shutdown_r <= 1'b0;
      thermal_stage_two_shutdown_r <= 1'b0;
      safe_r <= 1'b0;
      thermal_stage_two_shutdown_cnt_r <= 5'h00;
    end else if (ce) begin
      prewarn_r <= prewarn_nxt; // RULE_05
      thermal_stage_one_shutdown_r <= thermal_stage_one_shutdown_nxt; // RULE_05
      thermal_stage_two_shutdown_r <= thermal_stage_two_shutdown_nxt; // RULE_05
      safe_r <= safe_nxt; // RULE_05
      thermal_stage_two_shutdown_cnt_r <= thermal_stage_two_shutdown_cnt_nxt;
    end
  end

  // Device information flags. Restart leaves every bit here alone;
  // only reset returns the register to zero.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      crc_fail_r <= 1'b0; // RULE_19
      spi_fail_r <= 1'b0;
      failure_r <= 1'b0;
      prior_r <= tdsb_pkg::PRIOR_CLEARED;
    end else if (ce) begin
      crc_fail_r <= crc_fail_nxt;
      spi_fail_r <= spi_fail_nxt;
      failure_r <= failure_nxt;
      prior_r <= prior_nxt;
    end
  end

  // Answer register, one cycle after the request. The word is taken
  // from the flags before this cycle's events and clears land, so a
  // read-and-clear returns exactly the contents that it wipes. With
  // no request the word returns to zero, so the host must take it in
  // the cycle in which rsp_valid stands.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rsp_valid_r <= 1'b0;
      rsp_data_r <= tdsb_pkg::REG_RESET;
      crc_bypass_r <= 1'b0;
    end else if (ce) begin
      rsp_valid_r <= req.valid;
      rsp_data_r <= rsp_data_nxt;
      crc_bypass_r <= crc_bypass_nxt;
    end
  end

  // Fail-safe request pulse and module disables. The request stands
  // for one cycle per event, so the mode controller must latch it;
  // a lost pulse would leave the device out of its safe mode.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      fail_safe_r <= 1'b0;
      mod_dis_r <= '0;
    end else if (ce) begin
      fail_safe_r <= therm_evt.thermal_stage_two_shutdown; // RULE_02
      mod_dis_r <= mod_dis_nxt;
    end
  end

  // Outputs from flip-flops
  assign rsp_valid = rsp_valid_r;
  assign rsp_data = rsp_data_r;
  assign rsp_crc_bypass = crc_bypass_r;
  assign fail_safe_req = fail_safe_r;
  assign module_disable = mod_dis_r;

endmodule

//--- design/tdsb_wait_timer.sv
// Stage-two recovery wait timer with a short and a long interval.
// Assumes start is a pulse; a new start reloads the count.
`timescale 1ns/100ps
module tdsb_wait_timer #(
  parameter logic [39:0] SHORT_CYC = 40'h0000_0000_10,
  parameter logic [39:0] LONG_CYC = 40'h0000_0001_00
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic ce,
  input wire logic start,
  input wire logic long_sel,
  input wire logic abort,
  output logic busy
);

  logic [39:0] cnt_r;
  logic [39:0] cnt_nxt;
  wire [39:0] load = long_sel ? LONG_CYC : SHORT_CYC;

  // Down counter; zero means idle
  assign cnt_nxt = start ? load
                 : (abort ? 40'h0000_0000_00
                 : (cnt_r != 40'h0000_0000_00 ? cnt_r - 40'h0000_0000_01
                 : cnt_r));

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cnt_r <= 40'h0000_0000_00;
    end else if (ce) begin
      cnt_r <= cnt_nxt;
    end
  end

  assign busy = cnt_r != 40'h0000_0000_00;

endmodule

//--- testbench/tdsb_host_model.sv
// Host side of the status read path: read and read-clear accesses.
// Assumes the bench calls issue just after a falling edge.
`timescale 1ns/100ps
module tdsb_host_model (
  output tdsb_pkg::tdsb_req_type req
);
  initial req = '0;
  // Idle cycles still move the address, so a stale value is never trusted
  task automatic issue(input logic v, input logic [6:0] a, input logic rc);
    req = '{valid: v, addr: a, read_clear: rc};
  endtask
endmodule

//--- testbench/tdsb_status_bank_properties.sv
// Port-level checks of the thermal and device status bank.
// Assumes a bind into tdsb_status_bank and one clock domain.
`timescale 1ns/100ps
module tdsb_status_bank_properties (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic ce,
  input wire logic restart,
  input wire tdsb_pkg::tdsb_therm_evt_type therm_evt,
  input wire tdsb_pkg::tdsb_dev_evt_type dev_evt,
  input wire logic crc_enabled,
  input wire logic software_development_active_mode,
  input wire tdsb_pkg::tdsb_req_type req,
  input wire logic rsp_valid,
  input wire logic [15:0] rsp_data,
  input wire logic rsp_crc_bypass,
  input wire logic fail_safe_req,
  input wire logic [tdsb_pkg::NUM_MODULES-1:0] module_disable,
  input wire logic thermal_stage_two_shutdown_waiting,
  input wire logic long_wait_sel
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  // Accepted access to one address, and an accepted stage-two event
  sequence s_rd(logic [6:0] a);
    ce && req.valid && req.addr == a;
  endsequence
  sequence s_thermal_stage_two_shutdown;
    ce && therm_evt.thermal_stage_two_shutdown;
  endsequence
  a_therm_res_zero: assert property (
    s_rd(tdsb_pkg::ADDR_THERM) |=> rsp_data[15:4] == 12'h000)
    else $error("thermal reserved bits not zero");
  a_dev_res_zero: assert property (
    s_rd(tdsb_pkg::ADDR_DEV) |=> rsp_data[15:10] == 6'h00
    && !rsp_data[5] && rsp_data[7:6] != 2'h3)
    else $error("device word reserved bits or code wrong");
  a_crc_bit_live: assert property (
    s_rd(tdsb_pkg::ADDR_DEV) |=> rsp_valid
    && rsp_data[9] == $past(crc_enabled))
    else $error("crc enable bit wrong");
  a_swdev_bit_live: assert property (
    s_rd(tdsb_pkg::ADDR_DEV) |=> rsp_data[4] == $past(software_development_active_mode))
    else $error("development mode bit wrong");
  a_crc_bypass_dev: assert property (
    ce && req.valid |=> rsp_crc_bypass == ($past(req.addr) == 7'h42))
    else $error("crc bypass wrong");
  a_thermal_stage_two_shutdown_fail_safe: assert property (
    s_thermal_stage_two_shutdown |=> fail_safe_req && thermal_stage_two_shutdown_waiting)
    else $error("no fail-safe request after stage two");
  a_thermal_stage_two_shutdown_flag_kept: assert property (
    s_thermal_stage_two_shutdown ##1 s_rd(tdsb_pkg::ADDR_THERM) |=> rsp_data[2])
    else $error("stage-two flag not latched");
  a_thermal_stage_two_shutdown_prior_fail: assert property (
    s_thermal_stage_two_shutdown ##1 s_rd(tdsb_pkg::ADDR_DEV) |=> rsp_data[7:6] == 2'h1)
    else $error("prior state not failure");
  a_spi_fail_set: assert property (
    ce && dev_evt.invalid_cmd ##1 s_rd(tdsb_pkg::ADDR_DEV) |=> rsp_data[1])
    else $error("spi failure flag not set");
  a_thermal_stage_one_shutdown_module_only: assert property (
    ce && therm_evt.thermal_stage_one_shutdown && !restart |=> module_disable
    == ($past(module_disable) | $past(therm_evt.thermal_stage_one_shutdown_module)))
    else $error("wrong modules disabled");
  a_unmapped_zero: assert property (
    ce && req.valid && req.addr != 7'h41 && req.addr != 7'h42
    |=> rsp_data == 16'h0000)
    else $error("unmapped read not zero");
  a_reset_clear: assert property (
    $fell(reset) |-> !rsp_valid && rsp_data == 16'h0000 && !fail_safe_req
    && module_disable == '0 && !thermal_stage_two_shutdown_waiting)
    else $error("outputs not cleared by reset");
endmodule
bind tdsb_status_bank tdsb_status_bank_properties chk_u (
  .clk_sys(clk_sys), .reset(reset), .ce(ce), .restart(restart),
  .therm_evt(therm_evt), .dev_evt(dev_evt), .crc_enabled(crc_enabled),
  .software_development_active_mode(software_development_active_mode), .req(req), .rsp_valid(rsp_valid),
  .rsp_data(rsp_data), .rsp_crc_bypass(rsp_crc_bypass),
  .fail_safe_req(fail_safe_req), .module_disable(module_disable),
  .thermal_stage_two_shutdown_waiting(thermal_stage_two_shutdown_waiting), .long_wait_sel(long_wait_sel));

//--- testbench/tdsb_status_bank_tb.sv
// Self-checking bench: random events and accesses against a reference.
// Assumes short wait parameters so stage-two waits fit the run.
`timescale 1ns/100ps
module tdsb_status_bank_tb;
  logic clk_sys = 0;
  logic reset = 1;
  logic ce = 1;
  logic restart = 0;
  logic crc_enabled = 0;
  logic software_development_active_mode = 0;
  tdsb_pkg::tdsb_therm_evt_type therm_evt = '0;
  tdsb_pkg::tdsb_dev_evt_type dev_evt = '0;
  tdsb_pkg::tdsb_req_type req;
  logic rsp_valid, rsp_crc_bypass, fail_safe_req, thermal_stage_two_shutdown_waiting;
  logic long_wait_sel, crcf, spif, fail, pv, pb, pf;
  logic [15:0] rsp_data, pw, s;
  logic [3:0] module_disable, md, th;
  logic [4:0] cnt;
  logic [1:0] prior, wd;
  logic [7:0] t, d;
  logic [6:0] a;
  int seed = 38;
  int bad_count = 0;
  int total_checks = 0;
  always #2 clk_sys = ~clk_sys;
  tdsb_status_bank #(.WAIT_SHORT_CYC(40'h00_0000_0014),
    .WAIT_LONG_CYC(40'h00_0000_0032)) dut_u (.clk_sys(clk_sys),
    .reset(reset), .ce(ce), .restart(restart), .therm_evt(therm_evt),
    .dev_evt(dev_evt), .crc_enabled(crc_enabled), .software_development_active_mode(software_development_active_mode),
    .req(req), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .rsp_crc_bypass(rsp_crc_bypass), .fail_safe_req(fail_safe_req),
    .module_disable(module_disable), .thermal_stage_two_shutdown_waiting(thermal_stage_two_shutdown_waiting),
    .long_wait_sel(long_wait_sel));
  tdsb_host_model host_u (.req(req));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Read word from the reference state, before this cycle's events land
  function automatic logic [15:0] word(input logic [6:0] ad);
    if (ad == tdsb_pkg::ADDR_THERM) return {12'h000, th};
    if (ad != tdsb_pkg::ADDR_DEV) return 16'h0000;
    return {6'h00, crc_enabled, crcf, prior, 1'b0, software_development_active_mode, wd, spif,
      fail};
  endfunction
  // One clock: check last answers, drive new inputs, advance reference
  task automatic cyc(input logic [7:0] te, input logic [7:0] de,
    input logic v, input logic [6:0] ad, input logic rc, input logic rs);
    logic sset;
    @(negedge clk_sys);
    chk(16'(rsp_valid), 16'(pv));
    if (pv) begin
      chk(rsp_data, pw);
      chk(16'(rsp_crc_bypass), 16'(pb));
    end
    chk(16'(fail_safe_req), 16'(pf));
    chk(16'(module_disable), 16'(md));
    therm_evt = te;
    dev_evt = de;
    restart = rs;
    crc_enabled = 1'($random(seed));
    software_development_active_mode = 1'($random(seed));
    host_u.issue(v, ad, rc);
    pv = v;
    pw = word(ad);
    pb = ad == tdsb_pkg::ADDR_DEV;
    pf = therm_evt.thermal_stage_two_shutdown;
    sset = therm_evt.thermal_stage_two_shutdown && cnt >= 5'h10;
    #1 chk(16'(long_wait_sel), 16'(th[3] | sset));
    if (rs) md = 4'h0;
    if (therm_evt.thermal_stage_one_shutdown) md = md | therm_evt.thermal_stage_one_shutdown_module;
    if (v && rc && ad == tdsb_pkg::ADDR_THERM) th = 4'h0;
    th = th | {sset, therm_evt.thermal_stage_two_shutdown, therm_evt.thermal_stage_one_shutdown, therm_evt.prewarn};
    if (therm_evt.thermal_stage_two_shutdown && cnt != 5'h11) cnt = cnt + 5'h01;
    else if (!therm_evt.thermal_stage_two_shutdown && therm_evt.thermal_stage_two_shutdown_recovered) cnt = 5'h00;
    if (v && rc && ad == tdsb_pkg::ADDR_DEV) {crcf, prior, spif, fail} = '0;
    if (dev_evt.sleep_restart) prior = tdsb_pkg::PRIOR_SLEEP;
    if (dev_evt.fail_restart | dev_evt.watchdog_failure_count | therm_evt.thermal_stage_two_shutdown)
      prior = tdsb_pkg::PRIOR_FAIL;
    crcf = crcf | (dev_evt.crc_error & ~dev_evt.crc_static_seq);
    spif = spif | dev_evt.invalid_cmd;
    fail = fail | dev_evt.failure;
    if (dev_evt.wd_good) wd = 2'(dev_evt.watchdog_failure_count);
    else if (dev_evt.watchdog_failure_count && wd != 2'h3) wd = wd + 2'h1;
  endtask
  // Reset with quiet inputs, so nothing lands on the first free edge
  task automatic do_reset(input int n);
    reset = 1;
    therm_evt = '0;
    dev_evt = '0;
    restart = 0;
    host_u.issue(1'b0, 7'h00, 1'b0);
    repeat (n) @(negedge clk_sys);
    reset = 0;
    {th, cnt, md, prior, wd, crcf, spif, fail, pv, pf} = '0;
  endtask
  // Hang guard well past the planned run length
  initial begin
    #100000;
    bad_count++;
    test_done();
  end
  initial begin
    do_reset(5);
    repeat (2) begin
      cyc(8'h00, 8'h00, 1'b1, 7'h41, 1'b0, 1'b0);
      cyc(8'h00, 8'h00, 1'b1, 7'h42, 1'b0, 1'b0);
      repeat (3000) begin
        t = 8'($random(seed) & $random(seed) & $random(seed));
        d = 8'($random(seed) & $random(seed) & $random(seed));
        s = 16'($random(seed));
        a = s[1] ? 7'(s[9:3]) : (s[0] ? 7'h42 : 7'h41);
        cyc(t, d, s[10], a, s[11], s[15:12] == 4'h0 && !t[6]);
      end
      do_reset(2);
    end
    // Seventeen stage-two events in a row: the last one waits long
    repeat (17) cyc(8'h02, 8'h00, 1'b0, 7'h00, 1'b0, 1'b0);
    repeat (30) cyc(8'h00, 8'h00, 1'b0, 7'h15, 1'b0, 1'b0);
    chk(16'(thermal_stage_two_shutdown_waiting), 16'h0001);
    repeat (30) cyc(8'h00, 8'h00, 1'b0, 7'h2a, 1'b0, 1'b0);
    chk(16'(thermal_stage_two_shutdown_waiting), 16'h0000);
    // Clock enable low: an event and a clear must both leave no trace
    @(negedge clk_sys);
    ce = 0;
    therm_evt = 8'h82;
    host_u.issue(1'b1, 7'h41, 1'b1);
    repeat (3) @(negedge clk_sys);
    chk(16'(fail_safe_req), 16'h0000);
    chk(16'(thermal_stage_two_shutdown_waiting), 16'h0000);
    therm_evt = '0;
    host_u.issue(1'b0, 7'h00, 1'b0);
    ce = 1;
    cyc(8'h00, 8'h00, 1'b1, 7'h41, 1'b1, 1'b0);
    cyc(8'h00, 8'h00, 1'b1, 7'h41, 1'b0, 1'b0);
    cyc(8'h00, 8'h00, 1'b0, 7'h00, 1'b0, 1'b0);
    test_done();
  end
endmodule
